// file: core/cpu_status_control_defines.vh
// Purpose: constants for the cpu status and control block
// Assumes: 32-bit AHB-Lite register bus, word aligned
// Notes:   offsets and op codes are byte addresses / small codes
`ifndef CPU_STATUS_CONTROL_DEFINES_VH
`define CPU_STATUS_CONTROL_DEFINES_VH

// register byte addresses
`define OFS_STATUS     8'h00
`define OFS_CONTROL    8'h04
`define OFS_OPERAND_A  8'h08
`define OFS_OPERAND_B  8'h0c
`define OFS_COMMAND    8'h10
`define OFS_RESULT     8'h14
`define OFS_QUOTIENT   8'h18
`define OFS_REMAINDER  8'h1c
`define OFS_LOOP_CTRL  8'h20
`define OFS_ACC_EVENTS 8'h24
`define OFS_DIVIDEND_H 8'h28

// status bit positions
`define ST_OA   15
`define ST_OB   14
`define ST_SA   13
`define ST_SB   12
`define ST_OAB  11
`define ST_SAB  10
`define ST_DA   9
`define ST_DC   8
`define ST_RA   4
`define ST_N    3
`define ST_OV   2
`define ST_Z    1
`define ST_C    0

// control bit positions
`define CC_US    12
`define CC_EDT   11
`define CC_CPU_PRIORITY_TOP_BIT  3
`define CC_MEMORY_WRITE_CLIP_ENABLE 5

// reset values
`define CONTROL_RESET 16'h0020
`define STATUS_RESET  16'h0000

// alu op codes (command[3:0])
`define OP_ADD  4'h0
`define OP_SUB  4'h1
`define OP_AND  4'h2
`define OP_OR   4'h3
`define OP_XOR  4'h4
`define OP_SHL  4'h5
`define OP_SHR  4'h6
`define OP_MULS 4'h7
`define OP_MULU 4'h8
`define OP_MULSU 4'h9
`define OP_MULUS 4'ha
`define OP_MULLIT 4'hb
`define OP_MUL8 4'hc
`define OP_DIV  4'hd

// divide timing: one cycle per divisor bit plus three trailing cycles
`define DIV_BITS   16
`define DIV_CYCLES 19

`endif

// file: core/cpu_status_control_alu.v
// Purpose: status word, core control word, 16-bit alu, mul and divider
// Assumes: AHB-Lite slave, single word transfers, one clock
// Notes:   zero wait state bus; divide busy stretches nothing on the bus
`timescale 1ns/100ps
`include "cpu_status_control_defines.vh"

module cpu_status_control_alu
(
  input  wire        ref_clk_i,
  input  wire        reset_n_i,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hsel,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        nesting_block_i,
  input  wire        div_pause_i,
  output wire [3:0]  cpu_priority_level_o,
  output wire        user_irq_disable_o,
  output reg         do_loop_exit_o,
  output wire [15:0] control_word_o
);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  reg        wr_pend_q;
  reg [7:0]  wr_addr_q;
  reg        rd_pend_q;
  reg [7:0]  rd_addr_q;
  wire       take;

  assign take      = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      wr_addr_q <= haddr[7:0];
      rd_addr_q <= haddr[7:0];
    end
  end

  function is_addr;
    input [7:0] a;
    input [7:0] ofs;
    begin
      is_addr = (a == ofs);
    end
  endfunction

  wire [15:0] wd = hwdata[15:0];
  wire wr_status  = wr_pend_q & is_addr(wr_addr_q, `OFS_STATUS);
  wire wr_control = wr_pend_q & is_addr(wr_addr_q, `OFS_CONTROL);
  wire wr_cmd     = wr_pend_q & is_addr(wr_addr_q, `OFS_COMMAND);
  wire wr_loop    = wr_pend_q & is_addr(wr_addr_q, `OFS_LOOP_CTRL);
  wire wr_events  = wr_pend_q & is_addr(wr_addr_q, `OFS_ACC_EVENTS);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [15:0] op_a_q;
  reg [15:0] op_b_q;
  reg [15:0] div_hi_q;
  reg [15:0] result_q;
  reg [15:0] result_hi_q;
  reg [15:0] quotient_reg_q;
  reg [15:0] remainder_reg_q;
  reg        acc_a_overflow_q;
  reg        acc_b_overflow_q;
  reg        acc_a_clip_sticky_q;
  reg        acc_b_clip_sticky_q;
  reg        repeat_active_q;
  reg [2:0]  do_nest_depth_q;
  reg        half_carry_q;
  reg        negative_q;
  reg        signed_wrap_flag_q;
  reg        zero_q;
  reg        carry_q;
  reg [2:0]  cpu_priority_low_bits_q;
  reg        cpu_priority_top_bit_q;
  reg [15:0] ctrl_q;

  wire loop_do_active = (do_nest_depth_q != 3'h0);

  // ----------------------------------------------------------------
  // alu
  // ----------------------------------------------------------------
  reg  [16:0] sum;
  reg  [15:0] res;
  reg  [31:0] prod;
  reg         c_o;
  reg         dc_o;
  reg         ov_o;
  reg         flags_upd;
  wire [3:0]  op   = hwdata[3:0];
  wire        byte_op = hwdata[4];
  wire [15:0] b_in = (op == `OP_SUB) ? ~op_b_q : op_b_q;
  wire        cin  = (op == `OP_SUB);

  always @*
  begin
    sum  = 17'h00000;
    res  = 16'h0000;
    prod = 32'h00000000;
    c_o  = carry_q;
    dc_o = half_carry_q;
    ov_o = signed_wrap_flag_q;
    flags_upd = 1'b1;
    case (op)
      `OP_ADD, `OP_SUB:
      begin
        if (byte_op)
        begin
          sum = {8'h00, op_a_q[7:0]} + {8'h00, b_in[7:0]} + {16'h0000, cin};
          res = {8'h00, sum[7:0]};
          c_o = sum[8];
          dc_o = ((op_a_q[3:0] + b_in[3:0] + {3'h0, cin}) > 5'h0f);
          ov_o = (op_a_q[7] == b_in[7]) & (sum[7] != op_a_q[7]);
        end
        else
        begin
          sum = {1'b0, op_a_q} + {1'b0, b_in} + {16'h0000, cin};
          res = sum[15:0];
          c_o = sum[16];
          dc_o = ((op_a_q[7:0] + b_in[7:0] + {7'h00, cin}) > 9'h0ff);
          ov_o = (op_a_q[15] == b_in[15]) & (sum[15] != op_a_q[15]);
        end
      end
      `OP_AND: res = op_a_q & op_b_q;
      `OP_OR:  res = op_a_q | op_b_q;
      `OP_XOR: res = op_a_q ^ op_b_q;
      `OP_SHL:
      begin
        res = op_a_q << 1;
        c_o = byte_op ? op_a_q[7] : op_a_q[15];
      end
      `OP_SHR:
      begin
        res = op_a_q >> 1;
        c_o = op_a_q[0];
      end
      `OP_MULS:  prod = $signed(op_a_q) * $signed(op_b_q);
      `OP_MULU:  prod = op_a_q * op_b_q;
      `OP_MULSU: prod = $signed({op_a_q[15], op_a_q}) *
                        $signed({1'b0, op_b_q});
      `OP_MULUS: prod = $signed({1'b0, op_a_q}) *
                        $signed({op_b_q[15], op_b_q});
      `OP_MULLIT: prod = op_a_q * {11'h000, op_b_q[4:0]};
      `OP_MUL8:  prod = {16'h0000, {8'h00, op_a_q[7:0]} *
                                   {8'h00, op_b_q[7:0]}};
      default:   flags_upd = 1'b0;
    endcase
    if (op >= `OP_MULS && op <= `OP_MUL8)
    begin
      res = prod[15:0];
      flags_upd = 1'b0;
    end
    if (byte_op)
      res = {8'h00, res[7:0]};
  end

  wire res_neg = byte_op ? res[7] : res[15];

  // ----------------------------------------------------------------
  // divider: one cycle per divisor bit, pausable
  // ----------------------------------------------------------------
  reg        div_busy_q;
  reg [4:0]  div_cnt_q;
  reg [31:0] div_rem_q;
  reg [15:0] div_quo_q;
  reg [15:0] divisor_q;
  reg        div_neg_q;
  reg        div_rneg_q;
  wire [16:0] trial = {div_rem_q[31:15]} - {1'b0, divisor_q};
  wire        go_div = wr_cmd & (op == `OP_DIV) & ~div_busy_q;
  wire        div_signed = hwdata[5];
  wire        div_long   = hwdata[6];
  wire [31:0] dvd = div_long ? {div_hi_q, op_a_q}
                             : {{16{div_signed & op_a_q[15]}}, op_a_q};
  wire [31:0] dvd_abs = (div_signed & dvd[31]) ? (~dvd + 32'h1) : dvd;
  wire [15:0] dsr_abs = (div_signed & op_b_q[15]) ? (~op_b_q + 16'h1)
                                                  : op_b_q;

  always @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      div_busy_q <= 1'b0;
      div_cnt_q  <= 5'h00;
      div_rem_q  <= 32'h00000000;
      div_quo_q  <= 16'h0000;
      divisor_q  <= 16'h0000;
      div_neg_q  <= 1'b0;
      div_rneg_q <= 1'b0;
    end
    else if (go_div)
    begin
      div_busy_q <= 1'b1;
      div_cnt_q  <= 5'h00;
      div_rem_q  <= dvd_abs;
      div_quo_q  <= 16'h0000;
      divisor_q  <= dsr_abs;
      div_neg_q  <= div_signed & (dvd[31] ^ op_b_q[15]);
      div_rneg_q <= div_signed & dvd[31];
    end
    else if (div_busy_q & ~div_pause_i)
    begin
      div_cnt_q <= div_cnt_q + 5'h01;
      if (div_cnt_q < `DIV_BITS)
      begin
        if (!trial[16])
        begin
          div_rem_q <= {trial[15:0], div_rem_q[14:0], 1'b0};
          div_quo_q <= {div_quo_q[14:0], 1'b1};
        end
        else
        begin
          div_rem_q <= {div_rem_q[30:0], 1'b0};
          div_quo_q <= {div_quo_q[14:0], 1'b0};
        end
      end
      if (div_cnt_q == `DIV_CYCLES - 1)
        div_busy_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status and control
  // ----------------------------------------------------------------
  wire [3:0] acc_ev = hwdata[3:0];
  wire alu_go = wr_cmd & (op != `OP_DIV);

  always @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      op_a_q <= 16'h0000;
      op_b_q <= 16'h0000;
      div_hi_q <= 16'h0000;
      result_q <= 16'h0000;
      result_hi_q <= 16'h0000;
      quotient_reg_q <= 16'h0000;
      remainder_reg_q <= 16'h0000;
      acc_a_overflow_q <= 1'b0;
      acc_b_overflow_q <= 1'b0;
      acc_a_clip_sticky_q <= 1'b0;
      acc_b_clip_sticky_q <= 1'b0;
      repeat_active_q <= 1'b0;
      do_nest_depth_q <= 3'h0;
      {half_carry_q, negative_q, signed_wrap_flag_q} <= 3'h0;
      zero_q <= 1'b0;
      carry_q <= 1'b0;
      cpu_priority_low_bits_q <= 3'h0;
      cpu_priority_top_bit_q <= 1'b0;
      ctrl_q <= `CONTROL_RESET;
      do_loop_exit_o <= 1'b0;
    end
    else
    begin
      do_loop_exit_o <= 1'b0;
      if (wr_pend_q & is_addr(wr_addr_q, `OFS_OPERAND_A))
        op_a_q <= wd;
      if (wr_pend_q & is_addr(wr_addr_q, `OFS_OPERAND_B))
        op_b_q <= wd;
      if (wr_pend_q & is_addr(wr_addr_q, `OFS_DIVIDEND_H))
        div_hi_q <= wd;
      if (alu_go)
      begin
        result_q <= res;
        result_hi_q <= prod[31:16];
      end
      if (alu_go & flags_upd)
      begin
        carry_q <= c_o;
        half_carry_q <= dc_o;
        signed_wrap_flag_q <= ov_o;
        negative_q <= res_neg;
        zero_q <= (res == 16'h0000);
      end
      else if (wr_status)
      begin
        carry_q <= wd[`ST_C];
        zero_q <= wd[`ST_Z];
        signed_wrap_flag_q <= wd[`ST_OV];
        negative_q <= wd[`ST_N];
        half_carry_q <= wd[`ST_DC];
      end
      if (wr_status & ~nesting_block_i)
        cpu_priority_low_bits_q <= wd[7:5];
      if (div_busy_q & ~div_pause_i & (div_cnt_q == `DIV_CYCLES - 1))
      begin
        quotient_reg_q <= div_neg_q ? (~div_quo_q + 16'h1) : div_quo_q;
        remainder_reg_q <= div_rneg_q ? (~div_rem_q[31:16] + 16'h1)
                                      : div_rem_q[31:16];
      end
      if (wr_events)
      begin
        acc_a_overflow_q <= acc_ev[0];
        acc_b_overflow_q <= acc_ev[1];
      end
      if (wr_events & acc_ev[2])
        acc_a_clip_sticky_q <= 1'b1;
      else if (wr_status & (~wd[`ST_SA] | ~wd[`ST_SAB]))
        acc_a_clip_sticky_q <= 1'b0;
      if (wr_events & acc_ev[3])
        acc_b_clip_sticky_q <= 1'b1;
      else if (wr_status & (~wd[`ST_SB] | ~wd[`ST_SAB]))
        acc_b_clip_sticky_q <= 1'b0;
      if (wr_loop)
      begin
        repeat_active_q <= wd[0];
        if (wd[1] & (do_nest_depth_q != 3'h7))
          do_nest_depth_q <= do_nest_depth_q + 3'h1;
        else if (wd[2] & loop_do_active)
          do_nest_depth_q <= do_nest_depth_q - 3'h1;
      end
      if (wr_control)
      begin
        ctrl_q <= {3'h0, wd[`CC_US], 4'h0, wd[7:4], 1'b0, wd[2:0]};
        if (!wd[`CC_CPU_PRIORITY_TOP_BIT])
          cpu_priority_top_bit_q <= 1'b0;
        do_loop_exit_o <= wd[`CC_EDT] & loop_do_active;
      end
    end
  end

  // ----------------------------------------------------------------
  // read side
  // ----------------------------------------------------------------
  wire [15:0] status_word = {
    acc_a_overflow_q, acc_b_overflow_q,
    acc_a_clip_sticky_q, acc_b_clip_sticky_q,
    acc_a_overflow_q | acc_b_overflow_q,
    acc_a_clip_sticky_q | acc_b_clip_sticky_q,
    loop_do_active, half_carry_q, cpu_priority_low_bits_q,
    repeat_active_q, negative_q, signed_wrap_flag_q, zero_q, carry_q};

  wire [15:0] control_word = {ctrl_q[15:12], 1'b0, do_nest_depth_q,
                              ctrl_q[7:4], cpu_priority_top_bit_q,
                              ctrl_q[2:0]};

  assign control_word_o = control_word;
  assign cpu_priority_level_o = {cpu_priority_top_bit_q,
                                 cpu_priority_low_bits_q};
  assign user_irq_disable_o = cpu_priority_top_bit_q |
                              (cpu_priority_low_bits_q == 3'h7);

  always @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      hrdata <= 32'h00000000;
    else if (take & ~hwrite)
    begin
      if (haddr[7:0] == `OFS_STATUS)
        hrdata <= {16'h0000, status_word};
      else if (haddr[7:0] == `OFS_CONTROL)
        hrdata <= {16'h0000, control_word};
      else if (haddr[7:0] == `OFS_OPERAND_A)
        hrdata <= {16'h0000, op_a_q};
      else if (haddr[7:0] == `OFS_OPERAND_B)
        hrdata <= {16'h0000, op_b_q};
      else if (haddr[7:0] == `OFS_COMMAND)
        hrdata <= {31'h00000000, div_busy_q};
      else if (haddr[7:0] == `OFS_RESULT)
        hrdata <= {result_hi_q, result_q};
      else if (haddr[7:0] == `OFS_QUOTIENT)
        hrdata <= {16'h0000, quotient_reg_q};
      else if (haddr[7:0] == `OFS_REMAINDER)
        hrdata <= {16'h0000, remainder_reg_q};
      else if (haddr[7:0] == `OFS_DIVIDEND_H)
        hrdata <= {16'h0000, div_hi_q};
      else
        hrdata <= 32'h00000000;
    end
  end

endmodule // cpu_status_control_alu

// file: sim/cpu_status_control_alu_assertions.sv
// Purpose: port assertions for the status, control and alu block
// Assumes: bound to the top module, one clock domain
// Notes:   control writes land one cycle after the data phase
`timescale 1ns/100ps
`include "cpu_status_control_defines.vh"
module cpu_status_control_checker
(
  input wire        ref_clk_i,
  input wire        reset_n_i,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hsel,
  input wire        hready,
  input wire        nesting_block_i,
  input wire [3:0]  cpu_priority_level_o,
  input wire        user_irq_disable_o,
  input wire        do_loop_exit_o,
  input wire [15:0] control_word_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  level_top_a:
    assert property (cpu_priority_level_o[3] == control_word_o[3])
      else $error("priority top bit differs from control bit 3");
  irq_block_a:
    assert property (user_irq_disable_o == (cpu_priority_level_o[3] ||
      cpu_priority_level_o[2:0] == 3'h7))
      else $error("user interrupt block wrong for priority level");
  ctl_read_zero_a:
    assert property ({control_word_o[15:13], control_word_o[11]} == 4'h0)
      else $error("early exit or unused control bits read nonzero");
  ctl_reset_a:
    assert property ($rose(reset_n_i) |-> control_word_o ==
      `CONTROL_RESET && cpu_priority_level_o == 4'h0)
      else $error("control word or level wrong after reset");
  ctl_write_a:
    assert property (hsel && hready && htrans[1] && hwrite &&
      haddr[7:0] == `OFS_CONTROL |=> ##1
      {control_word_o[12], control_word_o[7:4], control_word_o[2:0]} ==
      $past({hwdata[12], hwdata[7:4], hwdata[2:0]}))
      else $error("control word did not take written fields");
  exit_pulse_a:
    assert property (do_loop_exit_o |=> !do_loop_exit_o)
      else $error("loop exit pulse longer than one cycle");
  exit_cause_a:
    assert property (do_loop_exit_o |-> $past(hwdata[11]) &&
      $past(control_word_o[10:8]) != 3'h0)
      else $error("loop exit without early exit write in a loop");
  ipl_lock_a:
    assert property ($past(nesting_block_i) && $past(reset_n_i) |->
      $stable(cpu_priority_level_o[2:0]))
      else $error("priority low bits changed while locked");
endmodule // cpu_status_control_checker

// file: sim/testbench.sv
// Purpose: self-checking bench for the status, control and alu block
// Assumes: one AHB-Lite master, slave answers with no wait state
// Notes:   ordinary alu cases run from a table
`timescale 1ns/100ps
`include "cpu_status_control_defines.vh"
module testbench;
  typedef struct packed {
    logic [3:0]  op;
    logic        bm;
    logic [15:0] a;
    logic [15:0] b;
    logic [31:0] r;
    logic [8:0]  s;
  } row_t;
  logic        ref_clk_i       = 1'b0;
  logic        reset_n_i       = 1'b0;
  logic [31:0] haddr           = 32'h0;
  logic [1:0]  htrans          = 2'h0;
  logic        hwrite          = 1'b0;
  logic [31:0] hwdata          = 32'h0;
  logic        hsel            = 1'b0;
  logic        nesting_block_i = 1'b0;
  logic        div_pause_i     = 1'b0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire  [3:0]  cpu_priority_level_o;
  wire         user_irq_disable_o;
  wire         do_loop_exit_o;
  wire  [15:0] control_word_o;
  row_t        tbl [17];
  int          n_errors = 0;
  int          compares = 0;
  int          exit_cnt = 0;
  logic [31:0] rm;
  logic [8:0]  sm;

  always #20 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
    if (do_loop_exit_o === 1'b1)
      exit_cnt <= exit_cnt + 1;

  cpu_status_control_alu u_cpu_status_control_alu
  (
    .ref_clk_i, .reset_n_i, .haddr, .htrans, .hwrite, .hwdata, .hsel,
    .hsize (3'h2), .hready (hreadyout), .hrdata, .hreadyout, .hresp,
    .nesting_block_i, .div_pause_i, .cpu_priority_level_o,
    .user_irq_disable_o, .do_loop_exit_o, .control_word_o
  );

  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic bus(input [7:0] a, input w, input [31:0] d,
                     output [31:0] r);
    @(posedge ref_clk_i);
    haddr  <= {24'h0, a};
    hwrite <= w;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    @(posedge ref_clk_i iff hreadyout === 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk_i iff hreadyout === 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp, input [31:0] m);
    compares++;
    if ((got & m) !== (exp & m))
    begin
      n_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got & m,
               exp & m);
    end
  endtask
  task automatic rc(input [7:0] a, input [31:0] exp, input [31:0] m);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(r, exp, m);
  endtask
  task automatic rst;
    reset_n_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    rc(`OFS_STATUS, 32'h0, 32'hffff);
    rc(`OFS_CONTROL, 32'h0020, 32'hffff);
  endtask
  task automatic dv(input [15:0] h, input [15:0] a, input [15:0] b,
                    input [7:0] c, input p, input [15:0] q,
                    input [15:0] rem);
    logic [31:0] r;
    wr(`OFS_DIVIDEND_H, {16'h0, h});
    wr(`OFS_OPERAND_A, {16'h0, a});
    wr(`OFS_OPERAND_B, {16'h0, b});
    wr(`OFS_COMMAND, {24'h0, c});
    if (p)
    begin
      div_pause_i <= 1'b1;
      repeat (30) @(posedge ref_clk_i);
      div_pause_i <= 1'b0;
    end
    rc(`OFS_COMMAND, 32'h1, 32'h1);
    r = 32'h1;
    for (int i = 0; i < 12 && r[0] !== 1'b0; i++)
      bus(`OFS_COMMAND, 1'b0, 32'h0, r);
    chk(r, 32'h0, 32'h1);
    rc(`OFS_QUOTIENT, {16'h0, q}, 32'hffff);
    rc(`OFS_REMAINDER, {16'h0, rem}, 32'hffff);
  endtask
  task automatic summarize;
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  initial
  begin
    tbl[0]  = '{4'h0, 1'b0, 16'h7fff, 16'h0001, 32'h00008000, 9'h10c};
    tbl[1]  = '{4'h0, 1'b0, 16'hffff, 16'h0001, 32'h00000000, 9'h103};
    tbl[2]  = '{4'h1, 1'b0, 16'h0005, 16'h0003, 32'h00000002, 9'h101};
    tbl[3]  = '{4'h1, 1'b0, 16'h0003, 16'h0005, 32'h0000fffe, 9'h008};
    tbl[4]  = '{4'h0, 1'b1, 16'h000f, 16'h0001, 32'h00000010, 9'h100};
    tbl[5]  = '{4'h0, 1'b1, 16'h0080, 16'h0080, 32'h00000000, 9'h007};
    tbl[6]  = '{4'h2, 1'b0, 16'hf0f0, 16'h0ff0, 32'h000000f0, 9'h000};
    tbl[7]  = '{4'h3, 1'b0, 16'hf0f0, 16'h0ff0, 32'h0000fff0, 9'h008};
    tbl[8]  = '{4'h4, 1'b0, 16'hf0f0, 16'h0ff0, 32'h0000ff00, 9'h008};
    tbl[9]  = '{4'h5, 1'b0, 16'h4001, 16'h0001, 32'h00008002, 9'h008};
    tbl[10] = '{4'h6, 1'b0, 16'h0002, 16'h0001, 32'h00000001, 9'h000};
    tbl[11] = '{4'h7, 1'b0, 16'hffff, 16'hffff, 32'h00000001, 9'h004};
    tbl[12] = '{4'h8, 1'b0, 16'hffff, 16'hffff, 32'hfffe0001, 9'h004};
    tbl[13] = '{4'h9, 1'b0, 16'hffff, 16'hffff, 32'hffff0001, 9'h004};
    tbl[14] = '{4'ha, 1'b0, 16'hffff, 16'hffff, 32'hffff0001, 9'h004};
    tbl[15] = '{4'hb, 1'b0, 16'h1234, 16'h003f, 32'h0002344c, 9'h004};
    tbl[16] = '{4'hc, 1'b0, 16'h12ff, 16'h34ff, 32'h0000fe01, 9'h004};
    rst();
    for (int i = 0; i < 17; i++)
    begin
      wr(`OFS_OPERAND_A, {16'h0, tbl[i].a});
      wr(`OFS_OPERAND_B, {16'h0, tbl[i].b});
      wr(`OFS_COMMAND, {27'h0, tbl[i].bm, tbl[i].op});
      rm = tbl[i].bm ? 32'h00ff : 32'hffff;
      if (tbl[i].op > 4'h6 && tbl[i].op < 4'hc)
        rm = 32'hffffffff;
      sm = tbl[i].op < 4'h2 ? 9'h10f : tbl[i].op < 4'h7 ? 9'h00a : 9'h10f;
      rc(`OFS_RESULT, tbl[i].r, rm);
      rc(`OFS_STATUS, {23'h0, tbl[i].s}, {23'h0, sm});
    end
    // multiply leaves flags, then a nonzero add clears zero
    wr(`OFS_STATUS, 32'h0002);
    wr(`OFS_COMMAND, 32'h7);
    rc(`OFS_STATUS, 32'h0002, 32'h000f);
    wr(`OFS_COMMAND, 32'h0);
    rc(`OFS_STATUS, 32'h0, 32'h0002);
    dv(16'h0, 16'h0064, 16'h0007, 8'h0d, 1'b1, 16'h000e, 16'h0002);
    dv(16'h0, 16'hff9c, 16'h0007, 8'h2d, 1'b0, 16'hfff2, 16'hfffe);
    dv(16'h1, 16'h2345, 16'h0100, 8'h4d, 1'b0, 16'h0123, 16'h0045);
    wr(`OFS_ACC_EVENTS, 32'h5);
    rc(`OFS_STATUS, 32'hac00, 32'hfe00);
    wr(`OFS_ACC_EVENTS, 32'ha);
    rc(`OFS_STATUS, 32'h7c00, 32'hfe00);
    wr(`OFS_STATUS, 32'h2400);
    rc(`OFS_STATUS, 32'h6c00, 32'hfe00);
    wr(`OFS_ACC_EVENTS, 32'h0);
    rc(`OFS_STATUS, 32'h2400, 32'hfe00);
    wr(`OFS_STATUS, 32'h3000);
    rc(`OFS_STATUS, 32'h0, 32'hfe00);
    wr(`OFS_STATUS, 32'hffff);
    rc(`OFS_STATUS, 32'h01ef, 32'hffff);
    chk({28'h0, cpu_priority_level_o}, 32'h7, 32'hf);
    chk({31'h0, user_irq_disable_o}, 32'h1, 32'h1);
    nesting_block_i <= 1'b1;
    wr(`OFS_STATUS, 32'h0);
    rc(`OFS_STATUS, 32'h00e0, 32'hffff);
    nesting_block_i <= 1'b0;
    wr(`OFS_STATUS, 32'h0040);
    rc(`OFS_STATUS, 32'h0040, 32'hffff);
    chk({28'h0, cpu_priority_level_o}, 32'h2, 32'hf);
    chk({31'h0, user_irq_disable_o}, 32'h0, 32'h1);
    wr(`OFS_CONTROL, 32'hffff);
    rc(`OFS_CONTROL, 32'h10f7, 32'hffff);
    chk({16'h0, control_word_o}, 32'h10f7, 32'hffff);
    wr(`OFS_CONTROL, 32'h0);
    rc(`OFS_CONTROL, 32'h0, 32'hffff);
    wr(`OFS_LOOP_CTRL, 32'h1);
    rc(`OFS_STATUS, 32'h0010, 32'h0210);
    wr(`OFS_CONTROL, 32'h0800);
    repeat (7) wr(`OFS_LOOP_CTRL, 32'h2);
    rc(`OFS_CONTROL, 32'h0700, 32'h0f00);
    rc(`OFS_STATUS, 32'h0200, 32'h0210);
    chk(exit_cnt, 32'h0, 32'hf);
    wr(`OFS_CONTROL, 32'h0800);
    rc(`OFS_CONTROL, 32'h0, 32'h0800);
    chk(exit_cnt, 32'h1, 32'hf);
    repeat (7) wr(`OFS_LOOP_CTRL, 32'h4);
    rc(`OFS_CONTROL, 32'h0, 32'h0700);
    rc(`OFS_STATUS, 32'h0, 32'h0210);
    wr(8'h40, 32'hffffffff);
    rc(8'h40, 32'h0, 32'hffffffff);
    chk({31'h0, hresp}, 32'h0, 32'h1);
    wr(`OFS_CONTROL, 32'h10d7);
    rst();
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    summarize();
  end
endmodule // testbench

bind cpu_status_control_alu cpu_status_control_checker
  u_cpu_status_control_checker
  (
    .ref_clk_i, .reset_n_i, .haddr, .htrans, .hwrite, .hwdata, .hsel,
    .hready, .nesting_block_i, .cpu_priority_level_o,
    .user_irq_disable_o, .do_loop_exit_o, .control_word_o
  );
